/* File: logic/lpm_controller.sv */
/*
  Low-power mode controller: supply supervision, regulator and power
  mode sequencing, oscillator gating, wake routing and clock failover.
  Assumes all inputs except event lines are synchronous to clock.
*/
`timescale 1ns/1ps
`default_nettype none
module lpm_controller #(
  parameter int WAKEUP_PIN_PINS   = lpm_pkg::LPM_WAKEUP_PIN_PINS,
  parameter int CSS_TIMEOUT = lpm_pkg::LPM_CSS_TIMEOUT_CYC
) (
  input  wire logic                               clock,
  input  wire logic                               resetn,
  input  wire lpm_pkg::lpm_supply_s               supply,
  input  wire logic                               pvd_enable,
  input  wire logic                               pvd_on_fall,
  input  wire logic                               pvd_on_rise,
  input  wire logic                               sleep_req,
  input  wire logic                               stop_req,
  input  wire logic                               standby_sel,
  input  wire logic                               stop_lp_reg,
  input  wire logic                               periph_irq,
  input  wire logic [lpm_pkg::LPM_EXT_LINES-1:0]  ext_lines,
  input  wire lpm_pkg::lpm_periph_wake_s          periph_wake,
  input  wire logic [lpm_pkg::LPM_LINES-1:0]      line_rise,
  input  wire logic [lpm_pkg::LPM_LINES-1:0]      line_fall,
  input  wire logic [lpm_pkg::LPM_LINES-1:0]      line_mask,
  input  wire logic [lpm_pkg::LPM_LINES-1:0]      line_pend_clr,
  input  wire logic                               external_reset_pin_n,
  input  wire logic                               independent_watchdog_rst,
  input  wire logic [WAKEUP_PIN_PINS-1:0]               wakeup_pin,
  input  wire logic [lpm_pkg::LPM_HSI_USERS-1:0]  hsi_req,
  input  wire logic                               ext_clk_select,
  input  wire logic                               ext_clk_beat,
  input  wire logic                               css_irq_en,
  output logic                                    device_reset_n,
  output logic                                    cpu_clk_en,
  output logic                                    periph_clk_en,
  output logic                                    core_clk_en,
  output logic                                    pll_en,
  output logic                                    internal_fast_rc_osc_en,
  output logic                                    external_fast_crystal_osc_en,
  output logic                                    core_domain_pwr,
  output lpm_pkg::lpm_reg_e                       reg_mode,
  output logic                                    sysclk_ext,
  output logic                                    rtc_wdg_run,
  output logic [lpm_pkg::LPM_HSI_USERS-1:0]       hsi_grant,
  output logic                                    pvd_irq,
  output logic                                    css_irq,
  output logic [lpm_pkg::LPM_LINES-1:0]           line_pending,
  output logic                                    event_irq
);
  import lpm_pkg::*;

  localparam logic [7:0] SETTLE = 8'(LPM_REG_SETTLE_CYC);

  lpm_state_e           state, next_state;
  logic                 pvd_q;
  logic                 reg_lp;
  logic [7:0]           settle_cnt;
  logic                 reg_ready;
  logic [WAKEUP_PIN_PINS-1:0] wk_q;
  logic                 wk_rise;
  logic                 standby_exit;
  logic                 por_ok;
  logic                 pdr_trip;
  logic                 css_fail;
  logic                 css_lock;
  logic                 clk_active;
  logic [LPM_LINES-1:0] lines;

  ////////////////////////////////////////////////////////////////////////
  // Supply supervision
  assign por_ok   = supply.main_ok;
  assign pdr_trip = !supply.main_ok ||
                    (!supply.analog_ok && !supply.analog_watch_off);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pvd_q   <= 1'b0;
      pvd_irq <= 1'b0;
    end else begin
      pvd_q   <= supply.pvd_below;
      pvd_irq <= pvd_enable &&
                 ((pvd_on_fall && supply.pvd_below && !pvd_q) ||
                  (pvd_on_rise && !supply.pvd_below && pvd_q));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Event lines
  assign lines = {1'b0, periph_wake.cec, periph_wake.comp, periph_wake.usart,
                  periph_wake.i2c, periph_wake.rtc,
                  supply.pvd_below & pvd_enable, ext_lines};

  lpm_event_lines #(.N(LPM_LINES)) u_events (
    .clock    (clock),
    .resetn   (resetn),
    .lines    (lines),
    .rise_sel (line_rise),
    .fall_sel (line_fall),
    .mask     (line_mask),
    .pend_clr (line_pend_clr),
    .pending  (line_pending),
    .req      (event_irq)
  );

  ////////////////////////////////////////////////////////////////////////
  // Standby wake sources
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) wk_q <= '0;
    else         wk_q <= wakeup_pin;
  end

  assign wk_rise      = |(wakeup_pin & ~wk_q);
  assign standby_exit = !external_reset_pin_n || independent_watchdog_rst ||
                        wk_rise || periph_wake.rtc;

  ////////////////////////////////////////////////////////////////////////
  // Power mode sequencing
  always_comb begin
    next_state = state;
    case (state)
      LPM_HOLD: begin
        if (por_ok && !pdr_trip && external_reset_pin_n &&
            !independent_watchdog_rst)
          next_state = LPM_RUN;
      end
      LPM_RUN: begin
        if (stop_req)
          next_state = standby_sel ? LPM_STANDBY : LPM_STOP;
        else if (sleep_req)
          next_state = LPM_SLEEP;
      end
      LPM_SLEEP: begin
        if (periph_irq || event_irq) next_state = LPM_RUN;
      end
      LPM_STOP: begin
        if (event_irq)
          next_state = LPM_RUN;
        else if (reg_lp && |hsi_req)
          next_state = LPM_STOP_REGUP;
      end
      LPM_STOP_REGUP: begin
        if (event_irq)      next_state = LPM_RUN;
        else if (!(|hsi_req)) next_state = LPM_STOP;
      end
      LPM_STANDBY: begin
        if (standby_exit) next_state = LPM_HOLD;
      end
      default: next_state = LPM_HOLD;
    endcase
    // Supervisor and reset sources outrank every mode
    if (state != LPM_HOLD &&
        (pdr_trip || !external_reset_pin_n || independent_watchdog_rst))
      next_state = LPM_HOLD;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) state <= LPM_HOLD;
    else         state <= next_state;
  end

  // Regulator choice is frozen at Stop entry
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn)
      reg_lp <= 1'b0;
    else if (state == LPM_RUN && next_state == LPM_STOP)
      reg_lp <= stop_lp_reg;
    else if (state == LPM_HOLD)
      reg_lp <= 1'b0;
  end

  // Main regulator must settle before the RC clock is handed out
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn)
      settle_cnt <= '0;
    else if (state != LPM_STOP_REGUP)
      settle_cnt <= '0;
    else if (settle_cnt != SETTLE)
      settle_cnt <= settle_cnt + 8'h01;
  end
  assign reg_ready = (state == LPM_STOP_REGUP) && (settle_cnt == SETTLE);

  ////////////////////////////////////////////////////////////////////////
  // System clock source and failover
  assign clk_active = sysclk_ext &&
                      (state == LPM_RUN || state == LPM_SLEEP);

  lpm_clk_monitor #(.TIMEOUT(CSS_TIMEOUT)) u_css (
    .clock  (clock),
    .resetn (resetn),
    .active (clk_active),
    .beat   (ext_clk_beat),
    .fail   (css_fail)
  );

  // After a failure the external source stays locked out until software
  // drops its select, so a dead oscillator is not picked again.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn)                     css_lock <= 1'b0;
    else if (css_fail)               css_lock <= 1'b1;
    else if (!ext_clk_select)        css_lock <= 1'b0;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sysclk_ext <= 1'b0;
      css_irq    <= 1'b0;
    end else begin
      css_irq <= css_fail && css_irq_en;
      if (state == LPM_HOLD || css_fail)
        sysclk_ext <= 1'b0;
      else if (state == LPM_RUN)
        sysclk_ext <= ext_clk_select && !css_lock;
      else if (state != LPM_SLEEP)
        sysclk_ext <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power and clock gating outputs
  assign rtc_wdg_run = 1'b1;

  always_comb begin
    device_reset_n               = 1'b1;
    cpu_clk_en                   = 1'b0;
    periph_clk_en                = 1'b0;
    core_clk_en                  = 1'b0;
    pll_en                       = 1'b0;
    internal_fast_rc_osc_en      = 1'b0;
    external_fast_crystal_osc_en = 1'b0;
    core_domain_pwr              = 1'b1;
    reg_mode                     = LPM_REG_MAIN;
    hsi_grant                    = '0;
    case (state)
      LPM_HOLD: begin
        device_reset_n          = 1'b0;
        internal_fast_rc_osc_en = 1'b1;
      end
      LPM_RUN, LPM_SLEEP: begin
        cpu_clk_en                   = (state == LPM_RUN);
        periph_clk_en                = 1'b1;
        core_clk_en                  = 1'b1;
        pll_en                       = 1'b1;
        internal_fast_rc_osc_en      = 1'b1;
        external_fast_crystal_osc_en = sysclk_ext;
        hsi_grant                    = hsi_req;
      end
      LPM_STOP: begin
        reg_mode = reg_lp ? LPM_REG_LP : LPM_REG_MAIN;
        if (!reg_lp) begin
          internal_fast_rc_osc_en = |hsi_req;
          hsi_grant               = hsi_req;
        end
      end
      LPM_STOP_REGUP: begin
        reg_mode                = LPM_REG_MAIN;
        internal_fast_rc_osc_en = reg_ready;
        hsi_grant               = reg_ready ? hsi_req : '0;
      end
      LPM_STANDBY: begin
        reg_mode        = LPM_REG_OFF;
        core_domain_pwr = 1'b0;
      end
      default: device_reset_n = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_regup_req;
    state == LPM_STOP && reg_lp && (|hsi_req) && !event_irq &&
    !pdr_trip && external_reset_pin_n && !independent_watchdog_rst;
  endsequence
  sequence s_standby_wake;
    state == LPM_STANDBY && wk_rise && !pdr_trip;
  endsequence

  AST_HOLD_ON_TRIP: assert property (pdr_trip |=> !device_reset_n)
    else $error("supply trip did not hold the device in reset");
  AST_ANALOG_OPT: assert property (state == LPM_RUN && supply.main_ok &&
      !supply.analog_ok && supply.analog_watch_off && !stop_req &&
      !sleep_req && external_reset_pin_n && !independent_watchdog_rst
      |=> state == LPM_RUN)
    else $error("disabled analog watch still caused reset");
  AST_PVD_FALL: assert property (pvd_enable && pvd_on_fall &&
      $rose(supply.pvd_below) |=> pvd_irq)
    else $error("supply fall below threshold gave no interrupt");
  AST_STANDBY_OFF: assert property (state == LPM_STANDBY |->
      reg_mode == LPM_REG_OFF && !core_domain_pwr &&
      !internal_fast_rc_osc_en && !external_fast_crystal_osc_en)
    else $error("standby left regulator or oscillator on");
  AST_SLEEP_CLKS: assert property (state == LPM_SLEEP |->
      !cpu_clk_en && periph_clk_en)
    else $error("sleep clock gating wrong");
  AST_STOP_CLKS: assert property (state == LPM_STOP |->
      !core_clk_en && !pll_en && !external_fast_crystal_osc_en)
    else $error("stop left a core clock running");
  AST_STOP_WAKE: assert property (state == LPM_STOP && event_irq &&
      !pdr_trip && external_reset_pin_n && !independent_watchdog_rst
      |=> state == LPM_RUN)
    else $error("enabled event did not leave stop");
  AST_REGUP_FIRST: assert property (s_regup_req |=>
      reg_mode == LPM_REG_MAIN && hsi_grant == '0)
    else $error("clock granted before regulator moved to main");
  AST_GRANT_MAIN: assert property ((|hsi_grant) |->
      reg_mode == LPM_REG_MAIN)
    else $error("rc clock granted on low-power regulator");
  AST_STANDBY_EXIT: assert property (s_standby_wake |=>
      !device_reset_n ##1 !sysclk_ext)
    else $error("wakeup pin did not restart through reset");
  AST_RESET_HSI: assert property (!device_reset_n |=> !sysclk_ext)
    else $error("external clock kept across reset");
  AST_CSS_FALLBACK: assert property (css_fail |=>
      !sysclk_ext && (css_irq == $past(css_irq_en)))
    else $error("clock failure handling wrong");

endmodule : lpm_controller
`default_nettype wire

/* File: logic/lpm_pkg.sv */
/*
  Shared constants, types and timing counts of the low-power mode
  controller. Assumes a single 250 MHz system clock.
*/
package lpm_pkg;

  typedef enum logic [2:0] {
    LPM_HOLD       = 3'h0,
    LPM_RUN        = 3'h1,
    LPM_SLEEP      = 3'h2,
    LPM_STOP       = 3'h3,
    LPM_STOP_REGUP = 3'h4,
    LPM_STANDBY    = 3'h5
  } lpm_state_e;

  typedef enum logic [1:0] {
    LPM_REG_OFF  = 2'h0,
    LPM_REG_LP   = 2'h1,
    LPM_REG_MAIN = 2'h2
  } lpm_reg_e;

  localparam int LPM_LINES      = 24;
  localparam int LPM_EXT_LINES  = 16;
  localparam int LPM_WAKEUP_PIN_PINS  = 2;
  localparam int LPM_HSI_USERS  = 3;
  // Event line map above the sixteen pin lines
  localparam int LPM_LINE_PVD   = 16;
  localparam int LPM_LINE_RTC   = 17;
  localparam int LPM_LINE_I2C   = 18;
  localparam int LPM_LINE_USART = 19;
  localparam int LPM_LINE_COMP0 = 20;
  localparam int LPM_LINE_COMP1 = 21;
  localparam int LPM_LINE_CEC   = 22;
  localparam int LPM_LINE_SPARE = 23;

  localparam int LPM_CLK_MHZ        = 250;
  localparam int LPM_REG_SETTLE_NS  = 20;
  localparam int LPM_REG_SETTLE_CYC =
    (LPM_REG_SETTLE_NS * LPM_CLK_MHZ + 999) / 1000;
  localparam int LPM_CSS_TIMEOUT_NS  = 2000;
  localparam int LPM_CSS_TIMEOUT_CYC =
    (LPM_CSS_TIMEOUT_NS * LPM_CLK_MHZ) / 1000;

  typedef struct packed {
    logic main_ok;
    logic analog_ok;
    logic analog_watch_off;
    logic pvd_below;
  } lpm_supply_s;

  typedef struct packed {
    logic       rtc;
    logic       i2c;
    logic       usart;
    logic [1:0] comp;
    logic       cec;
  } lpm_periph_wake_s;

endpackage : lpm_pkg

/* File: logic/lpm_event_lines.sv */
/*
  Edge detector lines with per-line edge select, mask and sticky
  pending flags. Line edges are caught by flops clocked by the line
  itself, so pulses shorter than a system clock period are kept.
*/
`timescale 1ns/1ps
`default_nettype none
module lpm_event_lines #(
  parameter int N = lpm_pkg::LPM_LINES
) (
  input  wire logic         clock,
  input  wire logic         resetn,
  input  wire logic [N-1:0] lines,
  input  wire logic [N-1:0] rise_sel,
  input  wire logic [N-1:0] fall_sel,
  input  wire logic [N-1:0] mask,
  input  wire logic [N-1:0] pend_clr,
  output logic      [N-1:0] pending,
  output logic              req
);
  import lpm_pkg::*;

  wire  [N-1:0] rise_tgl;
  wire  [N-1:0] fall_tgl;
  logic [N-1:0] rise_s1, rise_s2, rise_s3;
  logic [N-1:0] fall_s1, fall_s2, fall_s3;
  logic [N-1:0] hit;

  ////////////////////////////////////////////////////////////////////////
  // No dependence on the system clock for capture
  for (genvar i = 0; i < N; i++) begin : g_line
    logic r_t;
    logic f_t;
    always_ff @(posedge lines[i] or negedge resetn) begin
      if (!resetn) r_t <= 1'b0;
      else         r_t <= ~r_t;
    end
    always_ff @(negedge lines[i] or negedge resetn) begin
      if (!resetn) f_t <= 1'b0;
      else         f_t <= ~f_t;
    end
    assign rise_tgl[i] = r_t;
    assign fall_tgl[i] = f_t;
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rise_s1 <= '0; rise_s2 <= '0; rise_s3 <= '0;
      fall_s1 <= '0; fall_s2 <= '0; fall_s3 <= '0;
    end else begin
      rise_s1 <= rise_tgl; rise_s2 <= rise_s1; rise_s3 <= rise_s2;
      fall_s1 <= fall_tgl; fall_s2 <= fall_s1; fall_s3 <= fall_s2;
    end
  end

  assign hit = ((rise_s2 ^ rise_s3) & rise_sel) |
               ((fall_s2 ^ fall_s3) & fall_sel);

  // Set wins over a clear in the same cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) pending <= '0;
    else         pending <= (pending & ~pend_clr) | hit;
  end

  assign req = |(pending & mask);

  AST_PEND_STICKY: assert property (@(posedge clock) disable iff (!resetn)
    ((($past(pending) & ~pending) & ~$past(pend_clr)) == '0))
    else $error("pending flag dropped without a clear");
  AST_PEND_SET: assert property (@(posedge clock) disable iff (!resetn)
    (hit != '0) |=> ((pending & $past(hit)) == $past(hit)))
    else $error("detected edge not recorded as pending");

endmodule : lpm_event_lines
`default_nettype wire

/* File: logic/lpm_clk_monitor.sv */
/*
  External clock failure monitor. The external oscillator shows up as
  a heartbeat level that toggles; a missing toggle for TIMEOUT cycles
  while monitoring is active gives a one-cycle fail pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module lpm_clk_monitor #(
  parameter int TIMEOUT = lpm_pkg::LPM_CSS_TIMEOUT_CYC
) (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic active,
  input  wire logic beat,
  output logic      fail
);
  import lpm_pkg::*;

  localparam int CW = $clog2(TIMEOUT + 1);
  localparam logic [CW-1:0] LAST = CW'(TIMEOUT - 1);

  logic          beat_q;
  logic [CW-1:0] cnt;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) beat_q <= 1'b0;
    else         beat_q <= beat;
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt  <= '0;
      fail <= 1'b0;
    end else if (!active || beat != beat_q) begin
      cnt  <= '0;
      fail <= 1'b0;
    end else if (cnt == LAST) begin
      cnt  <= '0;
      fail <= 1'b1;
    end else begin
      cnt  <= cnt + 1'b1;
      fail <= 1'b0;
    end
  end

  AST_FAIL_ONLY_ACTIVE: assert property (@(posedge clock)
    disable iff (!resetn) fail |-> $past(active))
    else $error("clock fail raised while not monitoring");

endmodule : lpm_clk_monitor
`default_nettype wire

/* File: verification/lpm_wake_model.sv */
/*
  Wake source and external oscillator model for the controller bench.
  Assumes the bench sets alive and calls glitch() directly.
*/
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
module lpm_wake_model (
  input  wire logic        clock,
  input  wire logic        alive,
  output var  logic        beat,
  output var  logic [15:0] lines
);
  initial begin
    beat = 1'b0;
    lines = 16'h0000;
  end
  // A dead crystal freezes its level instead of toggling
  always @(posedge clock) begin
    if (alive)
      beat <= ~beat;
  end
  // Called on a falling edge: the pulse fits between two rising edges,
  // so only an asynchronous catch can see it
  task automatic glitch(input int i);
    #3 lines[i] = 1'b1;
    #2 lines[i] = 1'b0;
  endtask : glitch
endmodule : lpm_wake_model
`default_nettype wire

/* File: verification/lpm_controller_tb_top.sv */
/*
  Self-checking bench for the low-power mode controller.
  Assumes the wake model and a shortened clock monitor timeout.
*/
`timescale 1ns/1ps
`default_nettype none
module lpm_controller_tb_top;
  import lpm_pkg::*;
  localparam int TMO = 8;
  logic clock, resetn, pvd_enable, pvd_on_fall, pvd_on_rise, sleep_req;
  logic stop_req, standby_sel, stop_lp_reg, periph_irq, css_irq_en;
  logic external_reset_pin_n, independent_watchdog_rst, ext_clk_select;
  logic ext_clk_beat, alive, device_reset_n, cpu_clk_en, periph_clk_en;
  logic core_clk_en, pll_en, internal_fast_rc_osc_en, core_domain_pwr;
  logic external_fast_crystal_osc_en, sysclk_ext, rtc_wdg_run;
  logic pvd_irq, css_irq, event_irq;
  logic [1:0] wakeup_pin;
  logic [2:0] hsi_req, hsi_grant;
  logic [15:0] ext_lines;
  logic [23:0] line_rise, line_fall, line_mask, line_pend_clr, line_pending;
  lpm_supply_s supply;
  lpm_periph_wake_s periph_wake;
  lpm_reg_e reg_mode;
  int fail_count, n_compared;
////////////////////////////////////////
  lpm_controller #(.CSS_TIMEOUT(TMO)) u_lpm_controller (
    .clock, .resetn, .supply, .pvd_enable, .pvd_on_fall, .pvd_on_rise,
    .sleep_req, .stop_req, .standby_sel, .stop_lp_reg, .periph_irq,
    .ext_lines, .periph_wake, .line_rise, .line_fall, .line_mask,
    .line_pend_clr, .external_reset_pin_n, .independent_watchdog_rst,
    .wakeup_pin, .hsi_req, .ext_clk_select, .ext_clk_beat, .css_irq_en,
    .device_reset_n, .cpu_clk_en, .periph_clk_en, .core_clk_en, .pll_en,
    .internal_fast_rc_osc_en, .external_fast_crystal_osc_en,
    .core_domain_pwr, .reg_mode, .sysclk_ext, .rtc_wdg_run, .hsi_grant,
    .pvd_irq, .css_irq, .line_pending, .event_irq);
  lpm_wake_model u_lpm_wake_model (.clock, .alive, .beat(ext_clk_beat),
    .lines(ext_lines));
  task automatic chk(input string nm, input logic [23:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  // Outputs launched at the last rising edge have settled here
  task automatic mid;
    @(negedge clock);
  endtask : mid
  task automatic wrap_up;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task automatic wait_rst(input logic v);
    for (int k = 0; k < 12 && device_reset_n !== v; k++)
      mid;
    chk("rst", device_reset_n, v);
    if (device_reset_n !== v)
      wrap_up;
  endtask : wait_rst
  task automatic pulses(input bit css, input int n, input int exp);
    int c = 0;
    repeat (n) begin
      mid;
      if ((css ? css_irq : pvd_irq) === 1'b1)
        c++;
    end
    chk(css ? "css_irq" : "pvd_irq", c, exp);
  endtask : pulses
  task automatic enter(input logic sb, lp);
    cyc(1);
    {stop_req, standby_sel, stop_lp_reg} <= {1'b1, sb, lp};
    cyc(1);
    stop_req <= 1'b0;
  endtask : enter
////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    resetn = 1'b0;
    supply = 4'hc;
    {pvd_enable, pvd_on_fall, pvd_on_rise, sleep_req, stop_req} = '0;
    {standby_sel, stop_lp_reg, periph_irq, alive, ext_clk_select} = '0;
    {independent_watchdog_rst, wakeup_pin, hsi_req, periph_wake} = '0;
    {line_rise, line_fall, line_mask, line_pend_clr} = '0;
    {external_reset_pin_n, css_irq_en} = 2'h3;
    fail_count = 0;
    n_compared = 0;
    cyc(20);
    resetn <= 1'b1;
    cyc(2);
    mid;
    chk("reg", reg_mode, LPM_REG_MAIN);
    chk("rc", internal_fast_rc_osc_en, 1'b1);
    chk("sys", sysclk_ext, 1'b0);
    $display("test reset done");
    cyc(1);
    sleep_req <= 1'b1;
    cyc(1);
    sleep_req <= 1'b0;
    mid;
    chk("cpu per", {cpu_clk_en, periph_clk_en}, 2'h1);
    cyc(1);
    periph_irq <= 1'b1;
    cyc(1);
    periph_irq <= 1'b0;
    mid;
    chk("cpu", cpu_clk_en, 1'b1);
    $display("test sleep done");
    enter(1'b0, 1'b1);
    hsi_req <= 3'h2;
    {line_rise, line_mask} <= {24'h8, 24'h8};
    mid;
    chk("reg", reg_mode, LPM_REG_LP);
    chk("osc", {core_clk_en, pll_en, internal_fast_rc_osc_en,
      external_fast_crystal_osc_en, rtc_wdg_run}, 5'h01);
    cyc(1);
    mid;
    chk("reg hsi", {reg_mode, hsi_grant}, {LPM_REG_MAIN, 3'h0});
    cyc(6);
    mid;
    chk("hsi", hsi_grant, 3'h2);
    u_lpm_wake_model.glitch(3);
    cyc(5);
    mid;
    chk("pend", line_pending, 24'h8);
    chk("evt", event_irq, 1'b1);
    chk("cpu", cpu_clk_en, 1'b1);
    cyc(1);
    {hsi_req, line_pend_clr} <= {3'h0, 24'h8};
    cyc(1);
    line_pend_clr <= 24'h0;
    mid;
    chk("pend", line_pending, 24'h0);
    chk("evt", event_irq, 1'b0);
    $display("test stop done");
    enter(1'b1, 1'b0);
    mid;
    chk("reg", reg_mode, LPM_REG_OFF);
    chk("pwr", {core_domain_pwr, internal_fast_rc_osc_en, rtc_wdg_run},
      3'h1);
    cyc(1);
    wakeup_pin <= 2'h2;
    wait_rst(1'b0);
    wait_rst(1'b1);
    chk("rc", internal_fast_rc_osc_en, 1'b1);
    enter(1'b1, 1'b0);
    independent_watchdog_rst <= 1'b1;
    wait_rst(1'b0);
    cyc(1);
    {independent_watchdog_rst, standby_sel} <= 2'h0;
    wait_rst(1'b1);
    enter(1'b1, 1'b0);
    mid;
    chk("reg", reg_mode, LPM_REG_OFF);
    cyc(1);
    periph_wake.rtc <= 1'b1;
    wait_rst(1'b0);
    wait_rst(1'b1);
    cyc(1);
    periph_wake.rtc <= 1'b0;
    $display("test standby done");
    cyc(1);
    supply.main_ok <= 1'b0;
    wait_rst(1'b0);
    cyc(1);
    supply <= 4'ha;
    wait_rst(1'b1);
    cyc(4);
    mid;
    chk("rst", device_reset_n, 1'b1);
    cyc(1);
    supply.analog_watch_off <= 1'b0;
    wait_rst(1'b0);
    cyc(3);
    mid;
    chk("rst", device_reset_n, 1'b0);
    cyc(1);
    supply <= 4'hc;
    wait_rst(1'b1);
    $display("test supply done");
    cyc(1);
    pvd_enable <= 1'b1;
    // Fall below, rise above under each edge selection
    for (int i = 0; i < 4; i++) begin
      cyc(2);
      {pvd_on_fall, pvd_on_rise} <= (i < 2) ? 2'h2 : 2'h1;
      supply.pvd_below <= ~i[0];
      pulses(1'b0, 4, (i == 0 || i == 3) ? 1 : 0);
    end
    $display("test detector done");
    cyc(1);
    {alive, ext_clk_select} <= 2'h3;
    cyc(3);
    mid;
    chk("xo", {sysclk_ext, external_fast_crystal_osc_en}, 2'h3);
    cyc(1);
    alive <= 1'b0;
    pulses(1'b1, TMO + 6, 1);
    chk("sys", {sysclk_ext, internal_fast_rc_osc_en}, 2'h1);
    $display("test failover done");
    wrap_up;
  end
endmodule : lpm_controller_tb_top
`default_nettype wire
